// ---- hw/card_uart_consts.svh ----
// constants of the card uart receive path: register map, fields, reset values
`ifndef CARD_UART_CONSTS_SVH
`define CARD_UART_CONSTS_SVH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_MIXED_STATUS   8'h0c
`define IDX_RECEIVE_DATA   8'h0d
`define IDX_UART_STATUS    8'h0e
`define IDX_RX_CONTROL     8'h10
`define IDX_PARITY_LIMIT   8'h11

// ----------------------------------------------------------------------------
// mixed_status bit positions
// ----------------------------------------------------------------------------
`define MS_CLK_SWITCH      7
`define MS_FIFO_EMPTY      6
`define MS_GUARD_TIME      5
`define MS_CARD_PRESENT    2
`define MS_TX_RX_READY     0

// ----------------------------------------------------------------------------
// uart_status bit positions
// ----------------------------------------------------------------------------
`define US_PARITY_ERR      0
`define US_RX_FULL         1
`define US_FIFO_EMPTY      2

// ----------------------------------------------------------------------------
// rx_control fields and reset value
// ----------------------------------------------------------------------------
`define RC_DEPTH_LSB       0
`define RC_DEPTH_MSB       2
`define RC_PROTO_T1        3
`define RC_SYNC_MODE       4
`define RC_INVERSE         5
`define RC_UART_RESET_N    6
`define RC_CLK_SW_REQ      7
`define RC_RESET           8'h47

// ----------------------------------------------------------------------------
// parity_limit field and reset value
// ----------------------------------------------------------------------------
`define PL_LIMIT_LSB       0
`define PL_LIMIT_MSB       2
`define PL_RESET           8'h00

// ----------------------------------------------------------------------------
// guard time counts in etu
// ----------------------------------------------------------------------------
`define GUARD_ETU_T1       5'h16
`define GUARD_ETU_T0       5'h10

`endif

// ---- hw/card_uart_pkg.sv ----
// types shared by the card uart receive path
package card_uart_pkg;

  // ----------------------------------------------------------------------------
  // protocol selection
  // ----------------------------------------------------------------------------
  typedef enum logic {
    PROTO_T0 = 1'b0,
    PROTO_T1 = 1'b1
  } protocol_e;

  typedef logic [7:0] char_t;

endpackage

// ---- hw/rx_fifo_mem.sv ----
// character storage of the receive fifo with registered read data
`timescale 1ns/1ps
`default_nettype none

module rx_fifo_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output var  logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem_r [DEPTH];

  // storage write
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  // registered read of the entry at rd_addr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_r[rd_addr];
    end
  end

endmodule
`default_nettype wire

// ---- hw/card_uart_rx.sv ----
// card uart receive path: fifo, parity handling, status registers, apb slave
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "card_uart_consts.svh"

module card_uart_rx #(
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        rx_char_valid,
  input  wire logic [7:0]  rx_char_data,
  input  wire logic        rx_parity_err,
  input  wire logic        start_bit,
  input  wire logic        etu_tick,
  input  wire logic        card_io,
  input  wire logic        card_detect,
  input  wire logic        tx_mode_enter,
  input  wire logic        tx_char_done,
  input  wire logic        clk_on_internal,
  output var  logic        clock_switch_req,
  output var  logic        interrupt_out_n
);

  // ----------------------------------------------------------------------------
  // addresses
  // ----------------------------------------------------------------------------
  localparam logic [7:0] ADDR_MIXED  = 8'(`IDX_MIXED_STATUS * 4);
  localparam logic [7:0] ADDR_DATA   = 8'(`IDX_RECEIVE_DATA * 4);
  localparam logic [7:0] ADDR_STATUS = 8'(`IDX_UART_STATUS * 4);
  localparam logic [7:0] ADDR_CTRL   = 8'(`IDX_RX_CONTROL * 4);
  localparam logic [7:0] ADDR_PLIMIT = 8'(`IDX_PARITY_LIMIT * 4);

  // ----------------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------------
  logic [7:0]           rx_control_r;
  logic [2:0]           parity_limit_r;
  logic [3:0]           parity_cnt_r;
  logic                 parity_error_flag_r;
  logic [AW-1:0]        wr_ptr_r;
  logic [AW-1:0]        rd_ptr_r;
  logic [AW:0]          count_r;
  logic                 receive_buffer_full_flag_r;
  logic                 fifo_empty_flag_r;
  logic                 tx_rx_ready_flag_r;
  logic                 guard_time_flag_r;
  logic [4:0]           guard_cnt_r;
  logic                 clock_switch_done_r;
  logic                 card_present_flag_r;
  card_uart_pkg::char_t head_data;
  card_uart_pkg::char_t direct_char;
  card_uart_pkg::protocol_e proto;
  logic [AW:0]          depth;
  logic [3:0]           limit;
  logic [4:0]           guard_limit;
  logic                 soft_rst;
  logic                 access;
  logic                 done;
  logic                 wr_done;
  logic                 pop;
  logic                 push;
  logic                 perr_event;
  logic                 fifo_full;
  logic [AW:0]          count_nxt;
  logic                 mapped;

  // ----------------------------------------------------------------------------
  // control decode
  // ----------------------------------------------------------------------------
  assign proto    = card_uart_pkg::protocol_e'(rx_control_r[`RC_PROTO_T1]);
  assign depth    = (AW+1)'(rx_control_r[`RC_DEPTH_MSB:`RC_DEPTH_LSB]) + (AW+1)'(1);
  assign limit    = {1'b0, parity_limit_r} + 4'h1;
  assign soft_rst = !rx_control_r[`RC_UART_RESET_N];
  assign guard_limit = (proto == card_uart_pkg::PROTO_T1) ? `GUARD_ETU_T1
                                                          : `GUARD_ETU_T0;

  // ----------------------------------------------------------------------------
  // apb handshake terms
  // ----------------------------------------------------------------------------
  assign access  = psel && penable && !pready;
  assign done    = psel && penable && pready;
  assign wr_done = done && pwrite;
  assign mapped  = (paddr == ADDR_MIXED) || (paddr == ADDR_DATA) || (paddr == ADDR_STATUS)
                || (paddr == ADDR_CTRL) || (paddr == ADDR_PLIMIT);

  // ----------------------------------------------------------------------------
  // fifo push and pop
  // ----------------------------------------------------------------------------
  // convert inverse convention to direct: complement and reverse bit order
  always_comb begin
    direct_char = rx_char_data;
    if (rx_control_r[`RC_INVERSE]) begin
      for (int i = 0; i < 8; i++) begin
        direct_char[i] = !rx_char_data[7-i];
      end
    end
  end

  assign fifo_full  = (count_r >= depth);
  assign perr_event = rx_char_valid && rx_parity_err && !rx_control_r[`RC_SYNC_MODE];
  // T0 drops bad characters, T1 keeps them; no room means the character is lost
  assign push = rx_char_valid && !rx_control_r[`RC_SYNC_MODE] && !fifo_full
             && !(rx_parity_err && proto == card_uart_pkg::PROTO_T0);
  assign pop  = done && !pwrite && (paddr == ADDR_DATA) && (count_r != '0)
             && !rx_control_r[`RC_SYNC_MODE];
  assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);

  // storage
  rx_fifo_mem #(
    .WIDTH (8),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (push),
    .wr_addr (wr_ptr_r),
    .wr_data (direct_char),
    .rd_addr (rd_ptr_r),
    .rd_data (head_data)
  );

  // pointers wrap at the programmed depth
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else if (soft_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= ((AW+1)'(wr_ptr_r) + (AW+1)'(1) >= depth) ? '0 : wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= ((AW+1)'(rd_ptr_r) + (AW+1)'(1) >= depth) ? '0 : rd_ptr_r + AW'(1);
      end
      count_r <= count_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // fifo flags
  // ----------------------------------------------------------------------------
  // empty follows the fill level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_empty_flag_r <= 1'b1;
    end else if (soft_rst) begin
      fifo_empty_flag_r <= 1'b1;
    end else begin
      fifo_empty_flag_r <= (count_nxt == '0);
    end
  end

  // buffer full: set on filling, cleared by a data read; set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_buffer_full_flag_r <= 1'b0;
    end else if (soft_rst) begin
      receive_buffer_full_flag_r <= 1'b0;
    end else if (push && count_nxt >= depth) begin
      receive_buffer_full_flag_r <= 1'b1;
    end else if (pop) begin
      receive_buffer_full_flag_r <= 1'b0;
    end
  end

  // ready flag: tx entry, tx done, rx full; cleared by a data read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_rx_ready_flag_r <= 1'b0;
    end else if (soft_rst) begin
      tx_rx_ready_flag_r <= 1'b0;
    end else if (tx_mode_enter || tx_char_done || (push && count_nxt >= depth)) begin
      tx_rx_ready_flag_r <= 1'b1;
    end else if (pop) begin
      tx_rx_ready_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // parity error counter
  // ----------------------------------------------------------------------------
  // counts bad characters up to the limit, then holds until reloaded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parity_cnt_r        <= '0;
      parity_error_flag_r <= 1'b0;
    end else if (soft_rst) begin
      parity_cnt_r        <= '0;
      parity_error_flag_r <= 1'b0;
    end else if (wr_done && paddr == ADDR_PLIMIT) begin
      // reload restarts counting; an error in the same cycle still counts
      parity_cnt_r        <= perr_event ? 4'h1 : 4'h0;
      parity_error_flag_r <= perr_event && (pwdata[`PL_LIMIT_MSB:`PL_LIMIT_LSB] == 3'h0);
    end else if (perr_event && !parity_error_flag_r) begin
      parity_cnt_r <= parity_cnt_r + 4'h1;
      if (parity_cnt_r + 4'h1 >= limit) begin
        parity_error_flag_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // block guard time
  // ----------------------------------------------------------------------------
  // restart on each start bit, flag when the quiet count completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      guard_cnt_r       <= '0;
      guard_time_flag_r <= 1'b0;
    end else if (soft_rst || start_bit) begin
      guard_cnt_r       <= '0;
      guard_time_flag_r <= 1'b0;
    end else if (etu_tick && !guard_time_flag_r) begin
      guard_cnt_r <= guard_cnt_r + 5'h1;
      if (guard_cnt_r + 5'h1 >= guard_limit) begin
        guard_time_flag_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // clock switch, card presence, interrupt
  // ----------------------------------------------------------------------------
  // done flag follows the clock source once it matches the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_switch_done_r <= 1'b0;
    end else if (soft_rst) begin
      clock_switch_done_r <= 1'b0;
    end else if (rx_control_r[`RC_CLK_SW_REQ] && clk_on_internal) begin
      clock_switch_done_r <= 1'b1;
    end else if (!rx_control_r[`RC_CLK_SW_REQ] && !clk_on_internal) begin
      clock_switch_done_r <= 1'b0;
    end
  end

  // presence sample and interrupt line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_present_flag_r <= 1'b0;
      interrupt_out_n     <= 1'b1;
      clock_switch_req    <= 1'b0;
    end else begin
      card_present_flag_r <= card_detect;
      clock_switch_req    <= rx_control_r[`RC_CLK_SW_REQ];
      // full fifo interrupts; with depth one full means one character
      interrupt_out_n     <= !(parity_error_flag_r || receive_buffer_full_flag_r);
    end
  end

  // ----------------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------------
  // control and parity limit writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_control_r   <= `RC_RESET;
      parity_limit_r <= 3'(`PL_RESET);
    end else if (wr_done) begin
      if (paddr == ADDR_CTRL) begin
        rx_control_r <= pwdata[7:0];
      end
      if (paddr == ADDR_PLIMIT) begin
        parity_limit_r <= pwdata[`PL_LIMIT_MSB:`PL_LIMIT_LSB];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // apb read and answer
  // ----------------------------------------------------------------------------
  // one wait state: data and pready registered in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (access) begin
      pready  <= 1'b1;
      pslverr <= !mapped;
      prdata  <= '0;
      if (!pwrite) begin
        case (paddr)
          ADDR_MIXED: begin
            prdata[`MS_CLK_SWITCH]   <= clock_switch_done_r;
            prdata[`MS_FIFO_EMPTY]   <= fifo_empty_flag_r;
            prdata[`MS_GUARD_TIME]   <= guard_time_flag_r;
            prdata[`MS_CARD_PRESENT] <= card_present_flag_r;
            prdata[`MS_TX_RX_READY]  <= tx_rx_ready_flag_r;
          end
          ADDR_DATA: begin
            if (rx_control_r[`RC_SYNC_MODE]) begin
              prdata[0] <= card_io;
            end else begin
              prdata[7:0] <= head_data;
            end
          end
          ADDR_STATUS: begin
            prdata[`US_PARITY_ERR] <= parity_error_flag_r;
            prdata[`US_RX_FULL]    <= receive_buffer_full_flag_r;
            prdata[`US_FIFO_EMPTY] <= fifo_empty_flag_r;
          end
          ADDR_CTRL: begin
            prdata[7:0] <= rx_control_r;
          end
          ADDR_PLIMIT: begin
            prdata[`PL_LIMIT_MSB:`PL_LIMIT_LSB] <= parity_limit_r;
          end
          default: begin
            prdata <= '0;
          end
        endcase
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- test/card_uart_rx_props.sv ----
// port checks of the card uart receive path
`timescale 1ns/1ps
`default_nettype none
module card_uart_rx_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_char_valid,
  input wire logic        clock_switch_req,
  input wire logic        interrupt_out_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // apb answer: exactly one wait state, one-cycle pulse
  property p_acc_wait; psel && penable && !pready |=> pready; endproperty
  a_acc_wait: assert property (p_acc_wait) else $error("pready late");
  property p_one_pulse; pready |=> !pready; endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("pready too long");
  property p_rdy_in_acc; pready |-> psel && penable; endproperty
  a_rdy_in_acc: assert property (p_rdy_in_acc) else $error("pready outside access");
  property p_err_zero; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
  a_err_zero: assert property (p_err_zero) else $error("bad error answer");
  property p_hi_zero; pready |-> prdata[31:8] == 24'h00_0000; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
  // interrupt falls only two edges after a character strobe
  property p_int_fall; $fell(interrupt_out_n) |-> $past(rx_char_valid, 2); endproperty
  a_int_fall: assert property (p_int_fall) else $error("interrupt without char");
  // interrupt releases two edges after a read or reload, three after a soft reset write
  property p_int_rise;
    $rose(interrupt_out_n) |-> $past(psel && penable && pready, 2)
                               || $past(psel && penable && pready && pwrite, 3);
  endproperty
  a_int_rise: assert property (p_int_rise) else $error("interrupt released alone");
  property p_req_follow;
    $changed(clock_switch_req) |-> $past(psel && penable && pready && pwrite, 2);
  endproperty
  a_req_follow: assert property (p_req_follow) else $error("switch request moved");
  c_int: cover property ($fell(interrupt_out_n));
  c_err: cover property (pslverr);
  c_req: cover property ($rose(clock_switch_req));
endmodule
`default_nettype wire

// ---- test/card_model.sv ----
// behavioural smart card: start bits, character strobes and etu ticks
`timescale 1ns/1ps
`default_nettype none
module card_model (
  input  wire logic       pclk,
  output var  logic       rx_char_valid,
  output var  logic [7:0] rx_char_data,
  output var  logic       rx_parity_err,
  output var  logic       start_bit,
  output var  logic       etu_tick
);
  // idle lines at time zero
  initial begin
    rx_char_valid = 1'b0;
    rx_char_data  = 8'h00;
    rx_parity_err = 1'b0;
    start_bit     = 1'b0;
    etu_tick      = 1'b0;
  end
  // one start bit pulse
  task automatic start();
    @(posedge pclk);
    start_bit <= 1'b1;
    @(posedge pclk);
    start_bit <= 1'b0;
  endtask
  // one character with its parity verdict
  task automatic send(input logic [7:0] d, input logic pe);
    start();
    rx_char_valid <= 1'b1;
    rx_char_data  <= d;
    rx_parity_err <= pe;
    @(posedge pclk);
    rx_char_valid <= 1'b0;
    rx_char_data  <= ~d; // released lines show no stale value
    rx_parity_err <= ~pe;
  endtask
  // n etu ticks, one cycle each
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge pclk);
      etu_tick <= 1'b1;
      @(posedge pclk);
      etu_tick <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ---- test/test_card_uart_rx.sv ----
// self-checking bench of the card uart receive path
`timescale 1ns/1ps
`default_nettype none
module test_card_uart_rx;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, rx_char_data, got;
  logic [31:0] pwdata, prdata;
  logic        rx_char_valid, rx_parity_err, start_bit, etu_tick, card_io, card_detect;
  logic        tx_mode_enter, tx_char_done, clk_on_internal, clock_switch_req;
  logic        interrupt_out_n;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          dep[3] = '{1, 2, 8};
  int          n, lim;
  localparam logic [7:0] A_MS = 8'h30, A_RD = 8'h34, A_US = 8'h38, A_RC = 8'h40, A_PL = 8'h44;

  card_uart_rx dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_char_valid, .rx_char_data, .rx_parity_err, .start_bit, .etu_tick,
    .card_io, .card_detect, .tx_mode_enter, .tx_char_done, .clk_on_internal,
    .clock_switch_req, .interrupt_out_n);
  card_model card (.pclk, .rx_char_valid, .rx_char_data, .rx_parity_err, .start_bit,
    .etu_tick);

  // free-running 100 mhz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    got = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input string what, input logic [7:0] a, m, exp);
    apb(1'b0, a, 8'h00);
    chk(what, exp, got & m);
  endtask
  task automatic wr(input logic [7:0] a, d);
    apb(1'b1, a, d);
  endtask
  // soft reset through the control register, then the new setting
  task automatic sr(input logic [7:0] v);
    wr(A_RC, 8'h07);
    wr(A_RC, v);
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    #500000;
    n_mismatch++;
    tally_and_finish();
  end

  // test sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    card_io = 1'b0;
    card_detect = 1'b1;
    tx_mode_enter = 1'b0;
    tx_char_done = 1'b0;
    clk_on_internal = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd("mixed_status reset", A_MS, 8'hff, 8'h44);
    rd("uart_status reset", A_US, 8'hff, 8'h04);
    apb(1'b0, 8'h3c, 8'h00);
    chk("unmapped error", 8'h01, {7'h00, err});
    card_detect <= 1'b0;
    rd("card present", A_MS, 8'h04, 8'h00);
    card_detect <= 1'b1;
    $display("test reset done");
    for (int k = 0; k < 3; k++) begin
      n = dep[k];
      sr(8'h40 | 8'(n - 1));
      for (int i = 0; i <= n; i++) begin
        card.send(8'ha0 + 8'(i), 1'b0);
        wt(2);
        chk("interrupt", (i < n - 1) ? 8'h01 : 8'h00, {7'h00, interrupt_out_n});
      end
      rd("uart_status full", A_US, 8'hff, 8'h02);
      rd("mixed_status full", A_MS, 8'hff, 8'h05);
      for (int i = 0; i < n; i++) rd("receive_data", A_RD, 8'hff, 8'ha0 + 8'(i));
      rd("uart_status drained", A_US, 8'hff, 8'h04);
      rd("receive_data empty", A_RD, 8'hff, 8'ha0);
      rd("uart_status empty read", A_US, 8'hff, 8'h04);
      chk("interrupt released", 8'h01, {7'h00, interrupt_out_n});
    end
    $display("test fifo depth done");
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 2; k++) begin
        lim = k ? 8 : 1;
        sr(8'h47 | 8'(p << 3));
        wr(A_PL, 8'(lim - 1));
        for (int i = 1; i <= lim; i++) begin
          card.send(8'h5a, 1'b1);
          rd("parity flag", A_US, 8'h05, {5'h00, p == 0, 1'b0, i == lim});
        end
        chk("parity interrupt", 8'h00, {7'h00, interrupt_out_n});
        wr(A_PL, 8'(lim - 1));
        rd("parity flag reloaded", A_US, 8'h01, 8'h00);
      end
    end
    $display("test parity done");
    sr(8'h67);
    card.send(8'h3b, 1'b0);
    rd("inverse char", A_RD, 8'hff, 8'h23);
    sr(8'h57);
    card.send(8'h11, 1'b0);
    rd("sync no store", A_US, 8'hff, 8'h04);
    for (int v = 0; v < 2; v++) begin
      card_io <= v[0];
      rd("sync bit", A_RD, 8'h01, {7'h00, v[0]});
    end
    $display("test convention done");
    for (int p = 0; p < 2; p++) begin
      sr(8'h47 | 8'(p << 3));
      card.start();
      card.ticks(p ? 21 : 15);
      rd("guard early", A_MS, 8'h20, 8'h00);
      card.ticks(1);
      rd("guard", A_MS, 8'h20, 8'h20);
    end
    $display("test guard done");
    clk_on_internal <= 1'b1;
    wr(A_RC, 8'hc7);
    wt(2);
    chk("switch request", 8'h01, {7'h00, clock_switch_req});
    rd("switch done", A_MS, 8'h80, 8'h80);
    wr(A_RC, 8'h47);
    rd("switch pending", A_MS, 8'h80, 8'h80);
    clk_on_internal <= 1'b0;
    rd("switch back", A_MS, 8'h80, 8'h00);
    clk_on_internal <= 1'b1;
    wr(A_RC, 8'hc7);
    sr(8'h47);
    rd("switch soft reset", A_MS, 8'h80, 8'h00);
    clk_on_internal <= 1'b0;
    $display("test clock switch done");
    for (int i = 0; i < 2; i++) begin
      sr(8'h47);
      rd("ready idle", A_MS, 8'h01, 8'h00);
      tx_mode_enter <= (i == 0);
      tx_char_done  <= (i == 1);
      wt(1);
      tx_mode_enter <= 1'b0;
      tx_char_done  <= 1'b0;
      rd("ready flag", A_MS, 8'h01, 8'h01);
    end
    $display("test ready done");
    tally_and_finish();
  end
endmodule

bind card_uart_rx card_uart_rx_props u_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .prdata, .pready, .pslverr, .rx_char_valid, .clock_switch_req, .interrupt_out_n);
`default_nettype wire
